// file: src/pmc_mfr_regs.sv
// pmc_mfr_regs: manufacturer command register bank.
// assumes a single-cycle command port from the pmbus front end, one clock.
`timescale 1ns/1ps
module pmc_mfr_regs (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic        WR_STB,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        RD_STB,
    output logic      [15:0] RD_DATA,
    output logic             RD_VALID,
    output logic             RD_ERR,
    input  wire logic        VOUT_REQ_STB,
    input  wire logic [7:0]  VOUT_REQ_VID,
    input  wire logic        CLEAR_FAULTS,
    input  wire logic        SLEW_MODE_PIN,
    input  wire logic        SLEW_CFG_PROTO,
    input  wire logic        SLEW_CFG_VALID,
    input  wire logic [3:0]  OVERCURRENT_STRAP_PIN,
    input  wire logic [15:0] MEASURED_VOUT_VALUE,
    output logic      [7:0]  VOUT_CMD_VID,
    output logic             VID_PROTO_SEL,
    output logic      [7:0]  STATUS_BYTE,
    output logic      [15:0] STATUS_WORD,
    output logic      [7:0]  STATUS_VOUT,
    output logic             HOST_ALERT,
    output logic      [6:0]  VALLEY_CURRENT_AMPS,
    output logic      [17:0] PIN_AVG_US,
    output logic      [11:0] IV_AVG_US,
    output logic      [7:0]  VOUT_TRIM_CODE,
    output logic      [3:0]  TRIM_LSB_MV
);
    import pmc_pkg::*;

    // ==========================================
    // synchronisers for pin inputs
    logic [1:0] slew_pin_sync_reg;
    logic [3:0] oc_strap_s1_reg;
    logic [3:0] oc_strap_s2_reg;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            slew_pin_sync_reg <= 2'b00;
            oc_strap_s1_reg   <= 4'h0;
            oc_strap_s2_reg   <= 4'h0;
        end else if (CE) begin
            slew_pin_sync_reg <= {slew_pin_sync_reg[0], SLEW_MODE_PIN};
            oc_strap_s1_reg   <= OVERCURRENT_STRAP_PIN;
            oc_strap_s2_reg   <= oc_strap_s1_reg;
        end
    end

    // ==========================================
    // register state
    logic [7:0] min_vout_reg;
    logic [3:0] oc_code_reg;
    logic       oc_written_reg;
    logic [2:0] pin_avg_reg;
    logic [1:0] iv_avg_reg;
    logic [7:0] trim_reg;
    logic [3:0] rev_field_reg;
    logic [7:0] date_field_reg;
    logic [7:0] model_field_reg;

    function automatic logic wr_hit(input logic [7:0] code);
        return WR_STB && (CMD_CODE == code);
    endfunction : wr_hit

    // minimum limit: lower byte only, no nvm load
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            min_vout_reg <= MIN_VOUT_RESET;
        end else if (CE && wr_hit(CMD_MIN_VOUT_LIMIT)) begin
            min_vout_reg <= WR_DATA[7:0];
        end
    end

    // overcurrent code: strap until first write
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            oc_code_reg    <= OC_CODE_DEFAULT;
            oc_written_reg <= 1'b0;
        end else if (CE && wr_hit(CMD_PHASE_OC_LIMIT)) begin
            oc_code_reg    <= WR_DATA[3:0];
            oc_written_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_avg_reg <= TELEM_AVG_RESET[6:4];
            iv_avg_reg  <= TELEM_AVG_RESET[1:0];
        end else if (CE && wr_hit(CMD_TELEM_AVG)) begin
            pin_avg_reg <= WR_DATA[6:4];
            iv_avg_reg  <= WR_DATA[1:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trim_reg <= TRIM_DEFAULT;
        end else if (CE && wr_hit(CMD_VOUT_TRIM)) begin
            trim_reg <= WR_DATA[7:0];
        end
    end

    // text fields: only writable parts stored
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rev_field_reg   <= 4'h0;
            date_field_reg  <= TEXT_HIGH_DEFAULT;
            model_field_reg <= TEXT_HIGH_DEFAULT;
        end else if (CE) begin
            if (wr_hit(CMD_REVISION_TEXT)) begin
                rev_field_reg <= WR_DATA[11:8];
            end
            if (wr_hit(CMD_DATE_TEXT)) begin
                date_field_reg <= WR_DATA[15:8];
            end
            if (wr_hit(CMD_MODEL_TEXT)) begin
                model_field_reg <= WR_DATA[15:8];
            end
        end
    end

    // ==========================================
    // protocol select: config overrides strap
    logic proto_sel;
    assign proto_sel = SLEW_CFG_VALID ? SLEW_CFG_PROTO : slew_pin_sync_reg[1];

    logic [3:0] oc_code_eff;
    assign oc_code_eff = oc_written_reg ? oc_code_reg : oc_strap_s2_reg;

    // ==========================================
    // minimum clamp and warning
    logic [7:0] cmd_vid;
    logic       below_min;

    pmc_vout_guard u_guard (
        .req_vid   (VOUT_REQ_VID),
        .min_vid   (min_vout_reg),
        .cmd_vid   (cmd_vid),
        .below_min (below_min)
    );

    logic [7:0] vout_cmd_reg;
    logic       warn_reg;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            vout_cmd_reg <= MIN_VOUT_RESET;
        end else if (CE && VOUT_REQ_STB) begin
            vout_cmd_reg <= cmd_vid;
        end
    end

    // sticky warning; a new event beats a clear
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            warn_reg <= 1'b0;
        end else if (CE) begin
            if (VOUT_REQ_STB && below_min) begin
                warn_reg <= 1'b1;
            end else if (CLEAR_FAULTS) begin
                warn_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // read mux
    logic [15:0] rd_mux;
    logic        rd_hit;

    always_comb begin
        rd_hit = 1'b1;
        unique case (CMD_CODE)
            CMD_MODEL_TEXT:     rd_mux = {model_field_reg, TEXT_FIXED_LOW};
            CMD_REVISION_TEXT:  rd_mux = {REV_FIXED_HIGH, rev_field_reg, TEXT_FIXED_LOW};
            CMD_DATE_TEXT:      rd_mux = {date_field_reg, TEXT_FIXED_LOW};
            CMD_MIN_VOUT_LIMIT: rd_mux = {8'h00, min_vout_reg};
            CMD_PHASE_OC_LIMIT: rd_mux = {12'h000, oc_code_eff};
            CMD_TELEM_AVG:      rd_mux = {9'h000, pin_avg_reg, 2'b00, iv_avg_reg};
            CMD_MEASURED_VOUT:  rd_mux = MEASURED_VOUT_VALUE;
            CMD_VOUT_TRIM:      rd_mux = {8'h00, trim_reg};
            default: begin
                rd_mux = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RD_DATA  <= 16'h0000;
            RD_VALID <= 1'b0;
            RD_ERR   <= 1'b0;
        end else if (CE) begin
            RD_VALID <= RD_STB;
            RD_ERR   <= RD_STB && !rd_hit;
            if (RD_STB) begin
                RD_DATA <= rd_mux;
            end
        end
    end

    // ==========================================
    // decoded outputs, all registered
    logic [17:0] pin_us;
    logic [11:0] iv_us;

    pmc_avg_decode u_avg (
        .pin_code   (pin_avg_reg),
        .iv_code    (iv_avg_reg),
        .pin_avg_us (pin_us),
        .iv_avg_us  (iv_us)
    );

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            VOUT_CMD_VID        <= 8'h00;
            VID_PROTO_SEL       <= 1'b0;
            STATUS_BYTE         <= 8'h00;
            STATUS_WORD         <= 16'h0000;
            STATUS_VOUT         <= 8'h00;
            HOST_ALERT          <= 1'b0;
            VALLEY_CURRENT_AMPS <= OC_BASE_AMPS;
            PIN_AVG_US          <= 18'd0;
            IV_AVG_US           <= 12'd0;
            VOUT_TRIM_CODE      <= 8'h00;
            TRIM_LSB_MV         <= TRIM_LSB_MV_A;
        end else if (CE) begin
            VOUT_CMD_VID        <= vout_cmd_reg;
            VID_PROTO_SEL       <= proto_sel;
            STATUS_BYTE         <= 8'(warn_reg) << STAT_BYTE_OTHER;
            STATUS_WORD         <= 16'(warn_reg) << STAT_WORD_VOUT;
            STATUS_VOUT         <= 8'(warn_reg) << STAT_VOUT_MIN_WARN;
            HOST_ALERT          <= warn_reg;
            VALLEY_CURRENT_AMPS <= OC_BASE_AMPS + OC_STEP_AMPS * {3'b000, oc_code_eff};
            PIN_AVG_US          <= pin_us;
            IV_AVG_US           <= iv_us;
            VOUT_TRIM_CODE      <= trim_reg;
            TRIM_LSB_MV         <= proto_sel ? TRIM_LSB_MV_B : TRIM_LSB_MV_A;
        end
    end
endmodule : pmc_mfr_regs

// file: src/pmc_pkg.sv
// pmc_pkg: constants for the manufacturer command register bank.
// assumes a command-code/word register port driven by the pmbus front end.
package pmc_pkg;
    // ==========================================
    // command codes
    localparam logic [7:0] CMD_MODEL_TEXT     = 8'h9A;
    localparam logic [7:0] CMD_REVISION_TEXT  = 8'h9B;
    localparam logic [7:0] CMD_DATE_TEXT      = 8'h9D;
    localparam logic [7:0] CMD_MIN_VOUT_LIMIT = 8'hA4;
    localparam logic [7:0] CMD_PHASE_OC_LIMIT = 8'hD0;
    localparam logic [7:0] CMD_TELEM_AVG      = 8'hD1;
    localparam logic [7:0] CMD_MEASURED_VOUT  = 8'hD4;
    localparam logic [7:0] CMD_VOUT_TRIM      = 8'hD5;
    // ==========================================
    // fixed fields, arbitrary identity values
    localparam logic [7:0] TEXT_FIXED_LOW     = 8'h5A;
    localparam logic [3:0] REV_FIXED_HIGH     = 4'hA;
    // ==========================================
    // reset values and masks
    localparam logic [7:0] MIN_VOUT_RESET     = 8'h00;
    localparam logic [3:0] OC_CODE_DEFAULT    = 4'h8;
    localparam logic [7:0] TELEM_AVG_RESET    = 8'h50;
    localparam logic [7:0] TELEM_AVG_MASK     = 8'h73;
    localparam logic [7:0] TRIM_DEFAULT       = 8'h00;
    localparam logic [7:0] TEXT_HIGH_DEFAULT  = 8'h00;
    // ==========================================
    // overcurrent mapping, amps
    localparam logic [6:0] OC_BASE_AMPS       = 7'd24;
    localparam logic [6:0] OC_STEP_AMPS       = 7'd3;
    // trim lsb in mV per protocol
    localparam logic [3:0] TRIM_LSB_MV_A      = 4'd5;
    localparam logic [3:0] TRIM_LSB_MV_B      = 4'd10;
    // measured vout exponent
    localparam int         VOUT_EXPONENT      = -9;
    // ==========================================
    // status bit positions
    localparam int         STAT_BYTE_OTHER    = 0;
    localparam int         STAT_WORD_VOUT     = 15;
    localparam int         STAT_VOUT_MIN_WARN = 3;
endpackage : pmc_pkg

// file: src/pmc_avg_decode.sv
// pmc_avg_decode: averaging window lengths in microseconds.
// assumes codes come from the telemetry averaging register.
`timescale 1ns/1ps
module pmc_avg_decode (
    input  wire logic [2:0]  pin_code,
    input  wire logic [1:0]  iv_code,
    output logic      [17:0] pin_avg_us,
    output logic      [11:0] iv_avg_us
);
    import pmc_pkg::*;
    // ==========================================
    // input power window, zero means bypass
    always_comb begin
        unique case (pin_code)
            3'd0: pin_avg_us = 18'd0;
            3'd1: pin_avg_us = 18'd2000;
            3'd2: pin_avg_us = 18'd5500;
            3'd3: pin_avg_us = 18'd11500;
            3'd4: pin_avg_us = 18'd19000;
            3'd5: pin_avg_us = 18'd50000;
            3'd6: pin_avg_us = 18'd100000;
            3'd7: pin_avg_us = 18'd225000;
        endcase
    end
    // current and voltage window
    always_comb begin
        unique case (iv_code)
            2'd0: iv_avg_us = 12'd0;
            2'd1: iv_avg_us = 12'd500;
            2'd2: iv_avg_us = 12'd1000;
            2'd3: iv_avg_us = 12'd2500;
        endcase
    end
endmodule : pmc_avg_decode

// file: src/pmc_vout_guard.sv
// pmc_vout_guard: clamps requested vid against the minimum limit.
// assumes vid codes rise with voltage in both protocols.
`timescale 1ns/1ps
module pmc_vout_guard (
    input  wire logic [7:0] req_vid,
    input  wire logic [7:0] min_vid,
    output logic      [7:0] cmd_vid,
    output logic            below_min
);
    import pmc_pkg::*;
    // ==========================================
    // clamp and warn: minimum commanded instead
    always_comb begin
        below_min = (req_vid < min_vid);
        cmd_vid   = below_min ? min_vid : req_vid;
    end
endmodule : pmc_vout_guard

// file: verif/pmc_mfr_regs_chk.sv
// pmc_mfr_regs_chk: port assertions for the manufacturer register bank.
// assumes CE drops only around a trim write and one limit write at a time.
`timescale 1ns/1ps
module pmc_mfr_regs_chk
    import pmc_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic [7:0]  CMD_CODE,
    input wire logic        WR_STB,
    input wire logic [15:0] WR_DATA,
    input wire logic        RD_STB,
    input wire logic [15:0] RD_DATA,
    input wire logic        RD_VALID,
    input wire logic        RD_ERR,
    input wire logic        VOUT_REQ_STB,
    input wire logic [7:0]  VOUT_REQ_VID,
    input wire logic        CLEAR_FAULTS,
    input wire logic [15:0] MEASURED_VOUT_VALUE,
    input wire logic [7:0]  VOUT_CMD_VID,
    input wire logic        VID_PROTO_SEL,
    input wire logic [7:0]  STATUS_VOUT,
    input wire logic        HOST_ALERT,
    input wire logic [6:0]  VALLEY_CURRENT_AMPS,
    input wire logic [3:0]  TRIM_LSB_MV
);
    logic [7:0] min_reg;
    logic       mapped;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // ==========================================
    // shadow of the minimum limit
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            min_reg <= 8'h00;
        else if (WR_STB && CMD_CODE == CMD_MIN_VOUT_LIMIT)
            min_reg <= WR_DATA[7:0];
    end
    assign mapped = CMD_CODE inside {CMD_MODEL_TEXT, CMD_REVISION_TEXT, CMD_DATE_TEXT, CMD_MIN_VOUT_LIMIT,
                                     CMD_PHASE_OC_LIMIT, CMD_TELEM_AVG, CMD_MEASURED_VOUT, CMD_VOUT_TRIM};
    // ==========================================
    // assertions
    sequence s_low_req;
        VOUT_REQ_STB && (VOUT_REQ_VID < min_reg);
    endsequence
    sequence s_warned;
        HOST_ALERT && STATUS_VOUT[STAT_VOUT_MIN_WARN];
    endsequence
    a_clamp_to_min: assert property (s_low_req |-> ##2 (VOUT_CMD_VID == min_reg))
        else $error("commanded vid not clamped");
    a_warn_raised: assert property (s_low_req |-> ##2 s_warned)
        else $error("warning or alert missing");
    a_alert_held: assert property (HOST_ALERT && !CLEAR_FAULTS && !$past(CLEAR_FAULTS) |=> HOST_ALERT)
        else $error("alert dropped without clear");
    a_clear_drops: assert property (CLEAR_FAULTS && !VOUT_REQ_STB && !$past(VOUT_REQ_STB) |->
        ##2 !(HOST_ALERT || STATUS_VOUT[STAT_VOUT_MIN_WARN]))
        else $error("clear did not drop warning");
    a_read_answer: assert property (RD_STB |=> RD_VALID)
        else $error("read not answered");
    a_unmapped_err: assert property (RD_STB && !mapped |=> RD_ERR && RD_DATA == 16'h0000)
        else $error("unmapped read not refused");
    a_measured_ro: assert property (RD_STB && CMD_CODE == CMD_MEASURED_VOUT |=> RD_DATA == $past(MEASURED_VOUT_VALUE))
        else $error("measured vout read wrong");
    a_min_upper: assert property (RD_STB && CMD_CODE == CMD_MIN_VOUT_LIMIT |=> RD_DATA == {8'h00, min_reg})
        else $error("minimum limit read wrong");
    a_valley_map: assert property (WR_STB && CMD_CODE == CMD_PHASE_OC_LIMIT |->
        ##2 VALLEY_CURRENT_AMPS == OC_BASE_AMPS + OC_STEP_AMPS * $past(WR_DATA[3:0], 2))
        else $error("valley current wrong");
    a_trim_lsb: assert property (TRIM_LSB_MV == (VID_PROTO_SEL ? TRIM_LSB_MV_B : TRIM_LSB_MV_A))
        else $error("trim lsb wrong");
endmodule : pmc_mfr_regs_chk

// file: verif/pmc_host.sv
// pmc_host: command port master in the place of the pmbus front end.
// assumes the bank answers a read within four clocks.
`timescale 1ns/1ps
module pmc_host (
    input  wire logic        clk,
    output logic      [7:0]  cmd_code,
    output logic             wr_stb,
    output logic      [15:0] wr_data,
    output logic             rd_stb,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        rd_err
);
    initial begin
        cmd_code = 8'h00;
        wr_stb   = 1'b0;
        wr_data  = 16'h0000;
        rd_stb   = 1'b0;
    end
    // ==========================================
    // whole word in one beat, lines scrambled after release
    task automatic write_word(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        cmd_code <= c;
        wr_data  <= d;
        wr_stb   <= 1'b1;
        @(posedge clk);
        wr_stb   <= 1'b0;
        cmd_code <= ~c;
        wr_data  <= ~d;
    endtask : write_word
    task automatic read_word(input logic [7:0] c, output logic [15:0] d, output logic e, output logic ok);
        ok = 1'b0;
        @(posedge clk);
        cmd_code <= c;
        rd_stb   <= 1'b1;
        @(posedge clk);
        rd_stb   <= 1'b0;
        cmd_code <= ~c;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge clk);
            ok = rd_valid;
            d  = rd_data;
            e  = rd_err;
        end
    endtask : read_word
endmodule : pmc_host

// file: verif/testbench.sv
// testbench: scenarios for the manufacturer register bank.
// assumes pmc_host drives the command port; CE dropped once to show a freeze.
`timescale 1ns/1ps
module testbench;
    import pmc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, vstb = 1'b0, clr = 1'b0, slew_pin = 1'b0, cfg_proto = 1'b0, cfg_ok = 1'b0;
    logic        ce = 1'b1;
    logic        wstb, rstb, rvalid, rerr, alert, psel;
    logic [7:0]  code, vid = 8'h00, cvid, sbyte, svout, trim;
    logic [15:0] wdata, rdata, sword, mvout = 16'hB3C1;
    logic [3:0]  strap = 4'h3, lsb;
    logic [6:0]  amps;
    logic [17:0] pin_us;
    logic [11:0] iv_us;
    int          n_errors = 0, checks = 0;
    int          pin_tab[8] = '{0, 2000, 5500, 11500, 19000, 50000, 100000, 225000};
    int          iv_tab[4] = '{0, 500, 1000, 2500};
    pmc_mfr_regs dut (.CLK(clk), .RESET_N(rst_n), .CE(ce), .CMD_CODE(code), .WR_STB(wstb), .WR_DATA(wdata),
        .RD_STB(rstb), .RD_DATA(rdata), .RD_VALID(rvalid), .RD_ERR(rerr), .VOUT_REQ_STB(vstb), .VOUT_REQ_VID(vid),
        .CLEAR_FAULTS(clr), .SLEW_MODE_PIN(slew_pin), .SLEW_CFG_PROTO(cfg_proto), .SLEW_CFG_VALID(cfg_ok),
        .OVERCURRENT_STRAP_PIN(strap), .MEASURED_VOUT_VALUE(mvout), .VOUT_CMD_VID(cvid), .VID_PROTO_SEL(psel),
        .STATUS_BYTE(sbyte), .STATUS_WORD(sword), .STATUS_VOUT(svout), .HOST_ALERT(alert), .VALLEY_CURRENT_AMPS(amps),
        .PIN_AVG_US(pin_us), .IV_AVG_US(iv_us), .VOUT_TRIM_CODE(trim), .TRIM_LSB_MV(lsb));
    pmc_host host (.clk(clk), .cmd_code(code), .wr_stb(wstb), .wr_data(wdata), .rd_stb(rstb), .rd_data(rdata),
        .rd_valid(rvalid), .rd_err(rerr));
    initial begin
        forever #50 clk = ~clk;
    end
    // ==========================================
    // shared tasks
    task automatic finish_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] c, input logic e, input logic [15:0] x);
        logic [15:0] d;
        logic        er, ok;
        host.read_word(c, d, er, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            finish_test();
        end else
            chk({er, d}, {e, x});
    endtask : rd
    task automatic pulse(input logic is_clr, input logic [7:0] v);
        @(posedge clk);
        vstb <= !is_clr;
        clr  <= is_clr;
        vid  <= v;
        @(posedge clk);
        vstb <= 1'b0;
        clr  <= 1'b0;
        vid  <= ~v;
        repeat (3) @(posedge clk);
    endtask : pulse
    // ==========================================
    // scenarios
    task automatic t_fields;
        rd(CMD_TELEM_AVG, 1'b0, 16'h0050);
        rd(CMD_MIN_VOUT_LIMIT, 1'b0, 16'h0000);
        rd(CMD_VOUT_TRIM, 1'b0, 16'h0000);
        rd(CMD_PHASE_OC_LIMIT, 1'b0, 16'h0003);
        host.write_word(CMD_REVISION_TEXT, 16'hFFFF);
        rd(CMD_REVISION_TEXT, 1'b0, {REV_FIXED_HIGH, 4'hF, TEXT_FIXED_LOW});
        host.write_word(CMD_DATE_TEXT, 16'hC3FF);
        rd(CMD_DATE_TEXT, 1'b0, {8'hC3, TEXT_FIXED_LOW});
        host.write_word(CMD_MODEL_TEXT, 16'h77A5);
        rd(CMD_MODEL_TEXT, 1'b0, {8'h77, TEXT_FIXED_LOW});
        rd(8'h42, 1'b1, 16'h0000);
        host.write_word(CMD_MEASURED_VOUT, 16'h0000);
        rd(CMD_MEASURED_VOUT, 1'b0, 16'hB3C1);
        host.write_word(CMD_VOUT_TRIM, 16'hFF80);
        rd(CMD_VOUT_TRIM, 1'b0, 16'h0080);
        chk(trim, 8'h80);
        // write while frozen must not land
        ce <= 1'b0;
        host.write_word(CMD_VOUT_TRIM, 16'h0011);
        ce <= 1'b1;
        rd(CMD_VOUT_TRIM, 1'b0, 16'h0080);
        chk(trim, 8'h80);
        $display("test fields done");
    endtask : t_fields
    task automatic t_codes;
        for (int k = 0; k < 16; k++) begin
            host.write_word(CMD_PHASE_OC_LIMIT, {12'hFFF, k[3:0]});
            rd(CMD_PHASE_OC_LIMIT, 1'b0, {12'h000, k[3:0]});
            chk(amps, 24 + 3 * k);
        end
        for (int k = 0; k < 8; k++) begin
            host.write_word(CMD_TELEM_AVG, {8'hFF, 1'b1, k[2:0], 2'b11, k[1:0]});
            rd(CMD_TELEM_AVG, 1'b0, {9'h000, k[2:0], 2'b00, k[1:0]});
            chk(pin_us, pin_tab[k]);
            chk(iv_us, iv_tab[k[1:0]]);
        end
        $display("test codes done");
    endtask : t_codes
    task automatic t_proto;
        slew_pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk({psel, lsb}, {1'b1, 4'd10});
        cfg_ok <= 1'b1;
        repeat (4) @(posedge clk);
        chk({psel, lsb}, {1'b0, 4'd5});
        $display("test protocol done");
    endtask : t_proto
    task automatic t_clamp;
        host.write_word(CMD_MIN_VOUT_LIMIT, 16'hFF40);
        rd(CMD_MIN_VOUT_LIMIT, 1'b0, 16'h0040);
        pulse(1'b0, 8'h30);
        chk(cvid, 8'h40);
        chk({alert, sbyte[STAT_BYTE_OTHER], sword[STAT_WORD_VOUT], svout[STAT_VOUT_MIN_WARN]}, 4'hF);
        pulse(1'b0, 8'h55);
        chk({cvid, alert}, {8'h55, 1'b1});
        pulse(1'b1, 8'h00);
        chk({alert, sbyte[STAT_BYTE_OTHER], sword[STAT_WORD_VOUT], svout[STAT_VOUT_MIN_WARN]}, 4'h0);
        pulse(1'b0, 8'h40);
        chk({cvid, alert}, {8'h40, 1'b0});
        // low request and clear in one cycle: the warning is set
        @(posedge clk);
        vstb <= 1'b1;
        clr  <= 1'b1;
        vid  <= 8'h10;
        pulse(1'b0, 8'h50);
        chk({alert, svout[STAT_VOUT_MIN_WARN], cvid}, {2'b11, 8'h50});
        $display("test clamp done");
    endtask : t_clamp
    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk({alert, svout, cvid}, 17'h0_0000);
        rd(CMD_MIN_VOUT_LIMIT, 1'b0, 16'h0000);
        rd(CMD_TELEM_AVG, 1'b0, 16'h0050);
        rd(CMD_VOUT_TRIM, 1'b0, 16'h0000);
        rd(CMD_PHASE_OC_LIMIT, 1'b0, 16'h0003);
        chk(amps, 7'd33);
        $display("test reset done");
    endtask : t_reset
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_fields();
        t_codes();
        t_proto();
        t_clamp();
        t_reset();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end
endmodule : testbench
bind pmc_mfr_regs pmc_mfr_regs_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .CMD_CODE(CMD_CODE), .WR_STB(WR_STB),
    .WR_DATA(WR_DATA), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_ERR(RD_ERR),
    .VOUT_REQ_STB(VOUT_REQ_STB), .VOUT_REQ_VID(VOUT_REQ_VID), .CLEAR_FAULTS(CLEAR_FAULTS),
    .MEASURED_VOUT_VALUE(MEASURED_VOUT_VALUE), .VOUT_CMD_VID(VOUT_CMD_VID), .VID_PROTO_SEL(VID_PROTO_SEL),
    .STATUS_VOUT(STATUS_VOUT), .HOST_ALERT(HOST_ALERT), .VALLEY_CURRENT_AMPS(VALLEY_CURRENT_AMPS),
    .TRIM_LSB_MV(TRIM_LSB_MV));
